// ### logic/sbc_sup_pkg.sv
package sbc_sup_pkg;
  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_NS = 50;
  localparam int TEST_FILT_US = 64;
  localparam int TEST_FILT_CYC = (TEST_FILT_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int RF_US = 10;
  localparam int RF_CYC = (RF_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int RD_MS = 10;
  localparam int RD_CYC = RD_MS * (CLK_HZ / 1000);
  localparam int BLINK_FREQ_CHZ = 125;
  localparam longint BLINK_CYC_L = longint'(CLK_HZ) * 100 / BLINK_FREQ_CHZ;
  localparam int BLINK_CYC = int'(BLINK_CYC_L);
  localparam int PULSE_FREQ_HZ = 100;
  localparam int PULSE_CYC = CLK_HZ / PULSE_FREQ_HZ;
  localparam int FILT_W = 12;
  localparam int CNT_W = 24;
  typedef logic [FILT_W-1:0] filt_cnt_t;
  typedef logic [CNT_W-1:0] cnt_t;
  // ----------------------------------------
  // device modes as driven by the mode logic
  // ----------------------------------------
  localparam logic [2:0] MODE_INIT = 3'h0;
  localparam logic [2:0] MODE_NORMAL = 3'h1;
  localparam logic [2:0] MODE_STOP = 3'h2;
  localparam logic [2:0] MODE_SLEEP = 3'h3;
  localparam logic [2:0] MODE_RESTART = 3'h4;
  localparam logic [2:0] MODE_FAILSAFE = 3'h5;
  // ----------------------------------------
  // register map and fields
  // ----------------------------------------
  localparam logic [7:0] MODE_CTRL = 8'h00;
  localparam logic [7:0] FAIL_CTRL = 8'h04;
  localparam logic [7:0] PIN_CTRL = 8'h08;
  localparam logic [7:0] STATUS = 8'h0c;
  localparam int MODE_LSB = 0;
  localparam logic [1:0] SOFT_RESET_CODE = 2'h3;
  localparam int FORCE_ON_BIT = 0;
  localparam int DUTY_LSB = 1;
  localparam int SRRO_BIT = 3;
  localparam int UVT_LSB = 4;
  localparam int CFG2_LSB = 0;
  localparam int CFG3_LSB = 3;
  localparam int SW2_BIT = 6;
  localparam int SW3_BIT = 7;
  localparam int ST_FAIL_BIT = 0;
  localparam int ST_DEV_BIT = 1;
  localparam int ST_RO_BIT = 2;
  localparam int ST_FO_BIT = 3;
  localparam int ST_PIN2_BIT = 4;
  localparam int ST_PIN3_BIT = 5;
  localparam logic SRRO_RST = 1'b1;
  localparam logic [1:0] DUTY_RST = 2'h0;
  localparam logic [1:0] UVT_RST = 2'h0;
  localparam logic [2:0] CFG_FO = 3'h0;
  localparam logic [2:0] CFG_OFF = 3'h1;
  localparam logic [2:0] CFG_WAKE = 3'h2;
  localparam logic [2:0] CFG_LS = 3'h3;
  localparam logic [2:0] CFG_HS = 3'h4;
  localparam logic [1:0] DUTY_20 = 2'h0;
  localparam logic [1:0] DUTY_10 = 2'h1;
  localparam logic [1:0] DUTY_5 = 2'h2;
  localparam logic [1:0] DUTY_2P5 = 2'h3;
endpackage

// ### logic/stable_filter.sv
`timescale 1ns/100ps
module stable_filter #(
  parameter int N = 4,
  parameter logic RST_VAL = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_level,
  output logic o_level
);
  sbc_sup_pkg::filt_cnt_t cnt;

  // a level must hold n cycles before it is accepted
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt <= '0;
      o_level <= RST_VAL;
    end else if (i_level == o_level) begin
      cnt <= '0;
    end else if (cnt == sbc_sup_pkg::filt_cnt_t'(N - 1)) begin
      o_level <= i_level;
      cnt <= '0;
    end else begin
      cnt <= cnt + sbc_sup_pkg::filt_cnt_t'(1);
    end
  end

  sequence held_s;
    (i_level != o_level) ##1 (i_level != o_level);
  endsequence

  filter_accept_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $changed(o_level) |-> $past(cnt) == sbc_sup_pkg::filt_cnt_t'(N - 1) && o_level == $past(i_level))
    else $error("filter accepted a level too early");
  filter_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    held_s |-> cnt != '0 || $changed(o_level))
    else $error("filter count did not advance");
endmodule

// ### logic/pattern_gen.sv
`timescale 1ns/100ps
module pattern_gen #(
  parameter int PERIOD = 4
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_en,
  input wire sbc_sup_pkg::cnt_t i_on_cnt,
  output logic o_on
);
  sbc_sup_pkg::cnt_t cnt;

  // restarts at phase zero each time it is enabled
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt <= '0;
      o_on <= 1'b0;
    end else if (!i_en) begin
      cnt <= '0;
      o_on <= 1'b0;
    end else begin
      cnt <= (cnt == sbc_sup_pkg::cnt_t'(PERIOD - 1)) ? '0 : cnt + sbc_sup_pkg::cnt_t'(1);
      o_on <= cnt < i_on_cnt;
    end
  end

  pattern_off_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !i_en |=> !o_on && cnt == '0)
    else $error("pattern runs while disabled");
  pattern_start_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(o_on) |-> $past(cnt) == '0 || $past(i_on_cnt) != $past(i_on_cnt, 2))
    else $error("pattern on phase starts off period boundary");
endmodule

// ### logic/fail_reset_supervisor.sv
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
module fail_reset_supervisor #(
  parameter int RD_CYC = sbc_sup_pkg::RD_CYC,
  parameter int BLINK_CYC = sbc_sup_pkg::BLINK_CYC,
  parameter int PULSE_CYC = sbc_sup_pkg::PULSE_CYC
) (
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  output logic [31:0] O_HRDATA,
  input wire logic [2:0] I_SBC_MODE,
  input wire logic I_FAIL_COND,
  input wire logic I_WD_FAIL,
  input wire logic I_UV,
  input wire logic I_BLINKING_FAIL_OUT_I,
  input wire logic I_PULSED_FAIL_OUT_STRAP_PIN_I,
  output logic O_STATIC_FAIL_OUT_O,
  output logic O_STATIC_FAIL_OUT_OE,
  output logic O_BLINKING_FAIL_OUT_O,
  output logic O_BLINKING_FAIL_OUT_OE,
  output logic O_BLINKING_FAIL_OUT_WAKE_EN,
  output logic O_PULSED_FAIL_OUT_STRAP_PIN_O,
  output logic O_PULSED_FAIL_OUT_STRAP_PIN_OE,
  output logic O_PULSED_FAIL_OUT_STRAP_PIN_WAKE_EN,
  output logic O_RESET_OUT_PIN,
  output logic [1:0] O_UV_THRESH_SEL,
  output logic [1:0] O_MODE_REQ,
  output logic O_SOFT_RESET,
  output logic O_DEV_MODE
);
  typedef enum logic [1:0] {RO_HIGH = 2'b01, RO_LOW = 2'b10} ro_state_t;

  logic take;
  logic wr_pend;
  logic rd_pend;
  logic [7:0] addr;
  logic [31:0] rdata;
  logic in_normal;
  logic in_stop;
  logic halt;
  logic wr_mode;
  logic soft_req;
  logic force_on;
  logic [1:0] duty;
  logic srro;
  logic [2:0] cfg2;
  logic [2:0] cfg3;
  logic sw2;
  logic sw3;
  logic failure;
  logic fo_active;
  logic blink_on;
  logic pulse_on;
  sbc_sup_pkg::cnt_t pulse_on_cnt;
  logic test_lvl;
  logic prev_init;
  logic dev_done;
  logic uv_filt;
  logic assert_req;
  ro_state_t ro_state;
  ro_state_t next_ro;
  sbc_sup_pkg::cnt_t dly_cnt;
  sbc_sup_pkg::cnt_t next_dly;

  function automatic logic [2:0] pin_drive(input logic [2:0] cfg, input logic sw, input logic pat,
                                           input logic stop_sw, input logic wake_ok);
    pin_drive = 3'h0;
    case (cfg)
      sbc_sup_pkg::CFG_FO: pin_drive = {1'b0, pat, 1'b0};
      sbc_sup_pkg::CFG_WAKE: pin_drive = {1'b0, 1'b0, wake_ok};
      sbc_sup_pkg::CFG_LS: pin_drive = {1'b0, sw & ~stop_sw, 1'b0};
      sbc_sup_pkg::CFG_HS: pin_drive = {1'b1, sw & ~stop_sw, 1'b0};
      default: pin_drive = 3'h0;
    endcase
  endfunction

  // ----------------------------------------
  // ahb-lite slave
  // ----------------------------------------
  assign take = I_HSEL & I_HTRANS[1] & I_HREADY;
  assign in_normal = I_SBC_MODE == sbc_sup_pkg::MODE_NORMAL;
  assign in_stop = I_SBC_MODE == sbc_sup_pkg::MODE_STOP;
  assign halt = I_SBC_MODE == sbc_sup_pkg::MODE_RESTART || I_SBC_MODE == sbc_sup_pkg::MODE_FAILSAFE;

  // reads take one wait state so a write just before is visible
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr <= 8'h00;
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
    end else begin
      wr_pend <= take & I_HWRITE;
      rd_pend <= take & ~I_HWRITE;
      O_HREADYOUT <= ~(take & ~I_HWRITE);
      O_HRESP <= 1'b0;
      if (take) begin
        addr <= I_HADDR[7:0];
      end
    end
  end

  always_comb begin
    rdata = 32'h0000_0000;
    case (addr)
      sbc_sup_pkg::MODE_CTRL: rdata[sbc_sup_pkg::MODE_LSB +: 2] = O_MODE_REQ;
      sbc_sup_pkg::FAIL_CTRL: begin
        rdata[sbc_sup_pkg::FORCE_ON_BIT] = force_on;
        rdata[sbc_sup_pkg::DUTY_LSB +: 2] = duty;
        rdata[sbc_sup_pkg::SRRO_BIT] = srro;
        rdata[sbc_sup_pkg::UVT_LSB +: 2] = O_UV_THRESH_SEL;
      end
      sbc_sup_pkg::PIN_CTRL: begin
        rdata[sbc_sup_pkg::CFG2_LSB +: 3] = cfg2;
        rdata[sbc_sup_pkg::CFG3_LSB +: 3] = cfg3;
        rdata[sbc_sup_pkg::SW2_BIT] = sw2;
        rdata[sbc_sup_pkg::SW3_BIT] = sw3;
      end
      sbc_sup_pkg::STATUS: begin
        rdata[sbc_sup_pkg::ST_FAIL_BIT] = failure;
        rdata[sbc_sup_pkg::ST_DEV_BIT] = O_DEV_MODE;
        rdata[sbc_sup_pkg::ST_RO_BIT] = O_RESET_OUT_PIN;
        rdata[sbc_sup_pkg::ST_FO_BIT] = fo_active;
        rdata[sbc_sup_pkg::ST_PIN2_BIT] = I_BLINKING_FAIL_OUT_I;
        rdata[sbc_sup_pkg::ST_PIN3_BIT] = I_PULSED_FAIL_OUT_STRAP_PIN_I;
      end
      default: rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_HRDATA <= 32'h0000_0000;
    end else if (rd_pend) begin
      O_HRDATA <= rdata;
    end
  end

  // ----------------------------------------
  // mode request and soft reset
  // ----------------------------------------
  assign wr_mode = wr_pend && addr == sbc_sup_pkg::MODE_CTRL;
  assign soft_req = wr_mode && I_HWDATA[sbc_sup_pkg::MODE_LSB +: 2] == sbc_sup_pkg::SOFT_RESET_CODE
                    && (in_normal || in_stop);

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_SOFT_RESET <= 1'b0;
      O_MODE_REQ <= 2'h0;
    end else begin
      O_SOFT_RESET <= soft_req;
      if (O_SOFT_RESET) begin
        O_MODE_REQ <= 2'h0;
      end else if (wr_mode && I_HWDATA[sbc_sup_pkg::MODE_LSB +: 2] != sbc_sup_pkg::SOFT_RESET_CODE) begin
        O_MODE_REQ <= I_HWDATA[sbc_sup_pkg::MODE_LSB +: 2];
      end
    end
  end

  // ----------------------------------------
  // configuration, locked outside normal mode
  // ----------------------------------------
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      force_on <= 1'b0;
      duty <= sbc_sup_pkg::DUTY_RST;
      srro <= sbc_sup_pkg::SRRO_RST;
      O_UV_THRESH_SEL <= sbc_sup_pkg::UVT_RST;
    end else if (O_SOFT_RESET) begin
      force_on <= 1'b0;
      duty <= sbc_sup_pkg::DUTY_RST;
      srro <= sbc_sup_pkg::SRRO_RST;
      O_UV_THRESH_SEL <= sbc_sup_pkg::UVT_RST;
    end else if (wr_pend && addr == sbc_sup_pkg::FAIL_CTRL && in_normal) begin
      force_on <= I_HWDATA[sbc_sup_pkg::FORCE_ON_BIT];
      duty <= I_HWDATA[sbc_sup_pkg::DUTY_LSB +: 2];
      srro <= I_HWDATA[sbc_sup_pkg::SRRO_BIT];
      O_UV_THRESH_SEL <= I_HWDATA[sbc_sup_pkg::UVT_LSB +: 2];
    end
  end

  // register is never touched by mode changes, only by writes and a soft reset
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      cfg2 <= sbc_sup_pkg::CFG_FO;
      cfg3 <= sbc_sup_pkg::CFG_FO;
      sw2 <= 1'b0;
      sw3 <= 1'b0;
    end else if (O_SOFT_RESET) begin
      cfg2 <= sbc_sup_pkg::CFG_FO;
      cfg3 <= sbc_sup_pkg::CFG_FO;
      sw2 <= 1'b0;
      sw3 <= 1'b0;
    end else if (wr_pend && addr == sbc_sup_pkg::PIN_CTRL && in_normal) begin
      cfg2 <= I_HWDATA[sbc_sup_pkg::CFG2_LSB +: 3];
      cfg3 <= I_HWDATA[sbc_sup_pkg::CFG3_LSB +: 3];
      sw2 <= I_HWDATA[sbc_sup_pkg::SW2_BIT];
      sw3 <= I_HWDATA[sbc_sup_pkg::SW3_BIT];
    end
  end

  // ----------------------------------------
  // failure flag and fail outputs
  // ----------------------------------------
  // a live condition wins over any clear
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      failure <= 1'b0;
    end else if (I_FAIL_COND) begin
      failure <= 1'b1;
    end else if (O_SOFT_RESET) begin
      failure <= 1'b0;
    end else if (wr_pend && addr == sbc_sup_pkg::STATUS && in_normal && I_HWDATA[sbc_sup_pkg::ST_FAIL_BIT]) begin
      failure <= 1'b0;
    end
  end

  assign fo_active = failure | force_on;

  always_comb begin
    case (duty)
      sbc_sup_pkg::DUTY_20: pulse_on_cnt = sbc_sup_pkg::cnt_t'(PULSE_CYC / 5);
      sbc_sup_pkg::DUTY_10: pulse_on_cnt = sbc_sup_pkg::cnt_t'(PULSE_CYC / 10);
      sbc_sup_pkg::DUTY_5: pulse_on_cnt = sbc_sup_pkg::cnt_t'(PULSE_CYC / 20);
      sbc_sup_pkg::DUTY_2P5: pulse_on_cnt = sbc_sup_pkg::cnt_t'(PULSE_CYC / 40);
      default: pulse_on_cnt = sbc_sup_pkg::cnt_t'(PULSE_CYC / 5);
    endcase
  end

  pattern_gen #(.PERIOD(BLINK_CYC)) blink_gen (
    .i_clk(I_CLK),
    .i_nrst(I_NRST),
    .i_en(fo_active),
    .i_on_cnt(sbc_sup_pkg::cnt_t'(BLINK_CYC / 2)),
    .o_on(blink_on)
  );

  pattern_gen #(.PERIOD(PULSE_CYC)) pulse_gen (
    .i_clk(I_CLK),
    .i_nrst(I_NRST),
    .i_en(fo_active),
    .i_on_cnt(pulse_on_cnt),
    .o_on(pulse_on)
  );

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_STATIC_FAIL_OUT_O <= 1'b0;
      O_STATIC_FAIL_OUT_OE <= 1'b0;
      {O_BLINKING_FAIL_OUT_O, O_BLINKING_FAIL_OUT_OE, O_BLINKING_FAIL_OUT_WAKE_EN} <= 3'h0;
      {O_PULSED_FAIL_OUT_STRAP_PIN_O, O_PULSED_FAIL_OUT_STRAP_PIN_OE, O_PULSED_FAIL_OUT_STRAP_PIN_WAKE_EN} <= 3'h0;
    end else begin
      O_STATIC_FAIL_OUT_O <= 1'b0;
      O_STATIC_FAIL_OUT_OE <= fo_active;
      {O_BLINKING_FAIL_OUT_O, O_BLINKING_FAIL_OUT_OE, O_BLINKING_FAIL_OUT_WAKE_EN} <=
        pin_drive(cfg2, sw2, blink_on, halt, I_SBC_MODE != sbc_sup_pkg::MODE_FAILSAFE);
      {O_PULSED_FAIL_OUT_STRAP_PIN_O, O_PULSED_FAIL_OUT_STRAP_PIN_OE, O_PULSED_FAIL_OUT_STRAP_PIN_WAKE_EN} <=
        pin_drive(cfg3, sw3, pulse_on, halt, I_SBC_MODE != sbc_sup_pkg::MODE_FAILSAFE);
    end
  end

  // ----------------------------------------
  // strap sampling for development mode
  // ----------------------------------------
  stable_filter #(.N(sbc_sup_pkg::TEST_FILT_CYC), .RST_VAL(1'b1)) test_filt (
    .i_clk(I_CLK),
    .i_nrst(I_NRST),
    .i_level(I_PULSED_FAIL_OUT_STRAP_PIN_I),
    .o_level(test_lvl)
  );

  // only a power-up clears dev_done; a soft reset re-enters init without resampling
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      prev_init <= 1'b1;
      dev_done <= 1'b0;
      O_DEV_MODE <= 1'b0;
    end else begin
      prev_init <= I_SBC_MODE == sbc_sup_pkg::MODE_INIT;
      if (prev_init && I_SBC_MODE != sbc_sup_pkg::MODE_INIT && !dev_done) begin
        O_DEV_MODE <= ~test_lvl;
        dev_done <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // reset output
  // ----------------------------------------
  stable_filter #(.N(sbc_sup_pkg::RF_CYC), .RST_VAL(1'b0)) uv_filt_i (
    .i_clk(I_CLK),
    .i_nrst(I_NRST),
    .i_level(I_UV),
    .o_level(uv_filt)
  );

  assign assert_req = uv_filt | I_WD_FAIL | (O_SOFT_RESET & srro);

  always_comb begin
    next_ro = ro_state;
    next_dly = dly_cnt;
    case (ro_state)
      RO_HIGH: begin
        if (assert_req) begin
          next_ro = RO_LOW;
          next_dly = '0;
        end
      end
      RO_LOW: begin
        if (assert_req || I_UV) begin
          next_dly = '0;
        end else if (dly_cnt == sbc_sup_pkg::cnt_t'(RD_CYC - 1)) begin
          next_ro = RO_HIGH;
          next_dly = '0;
        end else begin
          next_dly = dly_cnt + sbc_sup_pkg::cnt_t'(1);
        end
      end
      default: begin
        next_ro = RO_LOW;
        next_dly = '0;
      end
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ro_state <= RO_LOW;
      dly_cnt <= '0;
      O_RESET_OUT_PIN <= 1'b0;
    end else begin
      ro_state <= next_ro;
      dly_cnt <= next_dly;
      O_RESET_OUT_PIN <= next_ro == RO_HIGH;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);

  sequence soft_cmd_s;
    wr_mode && I_HWDATA[1:0] == 2'h3;
  endsequence

  soft_ignore_a: assert property (soft_cmd_s and !(in_normal || in_stop) |=> !O_SOFT_RESET)
    else $error("soft reset taken outside normal or stop");
  soft_ro_a: assert property (O_SOFT_RESET && srro |=> !O_RESET_OUT_PIN ##1 srro)
    else $error("soft reset did not pull reset out low");
  wd_reset_a: assert property (I_WD_FAIL |=> !O_RESET_OUT_PIN)
    else $error("watchdog failure did not assert reset out");
  ro_release_a: assert property ($rose(O_RESET_OUT_PIN) |-> $past(dly_cnt) == sbc_sup_pkg::cnt_t'(RD_CYC - 1)
    && !$past(I_UV))
    else $error("reset out released before delay elapsed");
  fail_set_a: assert property (I_FAIL_COND |=> failure ##1 O_STATIC_FAIL_OUT_OE)
    else $error("failure did not activate fail outputs");
  fail_clear_a: assert property ($fell(failure) |-> !$past(I_FAIL_COND) && $past(in_normal || O_SOFT_RESET))
    else $error("failure flag cleared while condition present");
  force_on_a: assert property (force_on |=> O_STATIC_FAIL_OUT_OE)
    else $error("force bit did not drive fail output");
  cfg_lock_a: assert property (!in_normal && !O_SOFT_RESET |=> $stable(cfg2) && $stable(cfg3) && $stable(duty))
    else $error("settings changed outside normal mode");
  switch_halt_a: assert property (halt && cfg3 == sbc_sup_pkg::CFG_LS |=> !O_PULSED_FAIL_OUT_STRAP_PIN_OE)
    else $error("switch pin driven in restart or fail-safe");
  wake_off_a: assert property (I_SBC_MODE == sbc_sup_pkg::MODE_FAILSAFE |=> !O_BLINKING_FAIL_OUT_WAKE_EN)
    else $error("wake left enabled in fail-safe");
  dev_latch_a: assert property (dev_done |=> $stable(O_DEV_MODE))
    else $error("development mode selection changed after init");
endmodule

// ### tb/sup_partner.sv
`timescale 1ns/100ps
module sup_partner (
  input wire logic i_strap_low,
  input wire logic i_p2_o,
  input wire logic i_p2_oe,
  input wire logic i_p3_o,
  input wire logic i_p3_oe,
  output logic o_p2,
  output logic o_p3
);
  // --------------------------------
  // loads on the two pins: pull-up on p2, strap level on p3
  // --------------------------------
  // a released pin shows the pull-up, never the last driven level
  assign o_p2 = i_p2_oe ? i_p2_o : 1'b1;
  // strap held high except when a low strap is commanded
  assign o_p3 = i_p3_oe ? i_p3_o : !i_strap_low;
endmodule

// ### tb/fail_reset_supervisor_tb_top.sv
`timescale 1ns/100ps
module fail_reset_supervisor_tb_top;
  localparam int RD = 20;
  localparam int BL = 40;
  localparam int PU = 80;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0] mode = 3'h0;
  logic fail = 1'b0;
  logic wd = 1'b0;
  logic uv = 1'b0;
  logic strap_low = 1'b0;
  logic hready, hresp, rst_pin, sr, dev, p1o, p1oe, p2o, p2oe, p2wk, p3o, p3oe, p3wk, p2, p3;
  logic [1:0] uvt;
  logic [1:0] mreq;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [7:0] lf = 8'h5d;
  int n_fail = 0;
  int num_checks = 0;
  int sr_seen = 0;
  int c;
  initial begin
    forever #25 clk = ~clk;
  end
  always @(negedge clk) if (sr === 1'b1) sr_seen <= sr_seen + 1;
  fail_reset_supervisor #(.RD_CYC(RD), .BLINK_CYC(BL), .PULSE_CYC(PU)) dut_u (
    .I_CLK(clk), .I_NRST(nrst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
    .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready), .O_HREADYOUT(hready), .O_HRESP(hresp),
    .O_HRDATA(hrdata), .I_SBC_MODE(mode), .I_FAIL_COND(fail), .I_WD_FAIL(wd), .I_UV(uv),
    .I_BLINKING_FAIL_OUT_I(p2), .I_PULSED_FAIL_OUT_STRAP_PIN_I(p3), .O_STATIC_FAIL_OUT_O(p1o),
    .O_STATIC_FAIL_OUT_OE(p1oe), .O_BLINKING_FAIL_OUT_O(p2o), .O_BLINKING_FAIL_OUT_OE(p2oe),
    .O_BLINKING_FAIL_OUT_WAKE_EN(p2wk), .O_PULSED_FAIL_OUT_STRAP_PIN_O(p3o),
    .O_PULSED_FAIL_OUT_STRAP_PIN_OE(p3oe), .O_PULSED_FAIL_OUT_STRAP_PIN_WAKE_EN(p3wk),
    .O_RESET_OUT_PIN(rst_pin), .O_UV_THRESH_SEL(uvt), .O_MODE_REQ(mreq), .O_SOFT_RESET(sr), .O_DEV_MODE(dev));
  sup_partner far_u (.i_strap_low(strap_low), .i_p2_o(p2o), .i_p2_oe(p2oe), .i_p3_o(p3o), .i_p3_oe(p3oe),
    .o_p2(p2), .o_p3(p3));
  // --------------------------------
  // bench helpers
  // --------------------------------
  function automatic logic [7:0] nx(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic print_verdict;
    if (n_fail == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // level seen at the next rising edge is settled at the negedge before it
  task automatic rdy(output logic [31:0] d);
    int n;
    n = 0;
    @(negedge clk);
    while (hready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (n >= 100) begin
      n_fail++;
      print_verdict();
    end
    d = hrdata;
    @(posedge clk);
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wdat);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    rdy(rd);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wdat;
    rdy(rd);
    // step off the edge so a write that lands there is settled before any compare
    tick(1);
    chk("hresp_okay", hresp, 0);
  endtask
  task automatic cnt(input int s, input int n);
    c = 0;
    repeat (n) begin
      @(negedge clk);
      c += (s == 0) ? int'(p2oe) : (s == 1) ? int'(p3oe) : int'(!rst_pin);
    end
  endtask
  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    tick(16);
    chk("ro_in_reset", rst_pin, 0);
    @(posedge clk) nrst <= 1'b1;
    tick(RD - 4);
    chk("ro_powerup_low", rst_pin, 0);
    tick(1300);
    chk("ro_powerup_rel", rst_pin, 1);
    @(posedge clk) mode <= sbc_sup_pkg::MODE_NORMAL;
    tick(3);
    chk("dev_high_strap", dev, 0);
    ahb(0, sbc_sup_pkg::FAIL_CTRL, 0);
    chk("fail_ctrl_dflt", rd, 32'h8);
    ahb(0, 8'h40, 0);
    chk("unmapped", rd, 0);
    lf = nx(lf);
    ahb(1, sbc_sup_pkg::FAIL_CTRL, {26'h0, lf[1:0], 4'h8});
    chk("uvt_write", uvt, lf[1:0]);
    @(posedge clk) mode <= sbc_sup_pkg::MODE_STOP;
    ahb(1, sbc_sup_pkg::FAIL_CTRL, {26'h0, ~lf[1:0], 4'h8});
    chk("uvt_locked", uvt, lf[1:0]);
    @(posedge clk) mode <= sbc_sup_pkg::MODE_NORMAL;
    ahb(1, sbc_sup_pkg::PIN_CTRL, 32'h9a);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk) mode <= i == 0 ? sbc_sup_pkg::MODE_RESTART : i == 1 ? sbc_sup_pkg::MODE_FAILSAFE : 3'h1;
      tick(3);
      chk("wake_en", p2wk, i != 1);
      chk("switch_oe", p3oe, i == 2);
      chk("switch_low", p3o, 0);
      chk("wake3_off", p3wk, 0);
    end
    ahb(0, sbc_sup_pkg::PIN_CTRL, 0);
    chk("pin_ctrl_kept", rd, 32'h9a);
    ahb(1, sbc_sup_pkg::PIN_CTRL, 32'hcc);
    tick(3);
    chk("hs_level", p2o, 1);
    chk("hs_oe", p2oe, 1);
    chk("off_oe", p3oe, 0);
    ahb(1, sbc_sup_pkg::PIN_CTRL, 0);
    @(posedge clk) begin
      fail <= 1'b1;
      mode <= sbc_sup_pkg::MODE_RESTART;
    end
    tick(4);
    chk("static_on", p1oe, 1);
    chk("static_low", p1o, 0);
    cnt(0, BL);
    chk("blink_duty", c, BL / 2);
    @(posedge clk) mode <= sbc_sup_pkg::MODE_NORMAL;
    tick(3);
    chk("static_kept", p1oe, 1);
    for (int d = 0; d < 4; d++) begin
      ahb(1, sbc_sup_pkg::FAIL_CTRL, {26'h0, lf[1:0], 1'b1, 2'(d), 1'b0});
      tick(PU);
      cnt(1, PU);
      chk("pulse_duty", c, PU / (5 << d));
    end
    ahb(1, sbc_sup_pkg::STATUS, 1);
    tick(3);
    chk("clear_refused", p1oe, 1);
    ahb(0, sbc_sup_pkg::STATUS, 0);
    chk("status_fail", rd[sbc_sup_pkg::ST_FAIL_BIT], 1);
    @(posedge clk) fail <= 1'b0;
    ahb(1, sbc_sup_pkg::STATUS, 1);
    tick(3);
    chk("cleared", p1oe, 0);
    ahb(1, sbc_sup_pkg::FAIL_CTRL, 32'h9);
    tick(3);
    chk("force_on", p1oe, 1);
    ahb(1, sbc_sup_pkg::FAIL_CTRL, 32'h8);
    tick(3);
    chk("force_off", p1oe, 0);
    // short dips must be swallowed by the filter
    lf = nx(lf);
    @(posedge clk) uv <= 1'b1;
    cnt(2, 50 + int'(lf[6:0]));
    @(posedge clk) uv <= 1'b0;
    chk("uv_short", c, 0);
    @(posedge clk) uv <= 1'b1;
    cnt(2, 195);
    chk("uv_filter", c, 0);
    tick(20);
    chk("uv_low", rst_pin, 0);
    @(posedge clk) uv <= 1'b0;
    // the filter also holds the end of a dip, so the delay starts once it lets go
    tick(sbc_sup_pkg::RF_CYC + RD - 4);
    chk("uv_delay", rst_pin, 0);
    tick(8);
    chk("uv_release", rst_pin, 1);
    @(posedge clk) wd <= 1'b1;
    @(posedge clk) wd <= 1'b0;
    tick(2);
    chk("wd_low", rst_pin, 0);
    tick(RD + 6);
    chk("wd_release", rst_pin, 1);
    @(posedge clk) mode <= sbc_sup_pkg::MODE_SLEEP;
    ahb(1, sbc_sup_pkg::MODE_CTRL, 3);
    tick(3);
    chk("sr_ignored", sr_seen, 0);
    chk("sr_ign_ro", rst_pin, 1);
    @(posedge clk) mode <= sbc_sup_pkg::MODE_NORMAL;
    ahb(1, sbc_sup_pkg::FAIL_CTRL, 0);
    ahb(1, sbc_sup_pkg::MODE_CTRL, 2);
    chk("mode_req", mreq, 2);
    ahb(1, sbc_sup_pkg::MODE_CTRL, 3);
    cnt(2, RD + 5);
    chk("sr_no_pulse", c, 0);
    chk("sr_seen", sr_seen, 1);
    chk("sr_mode_req", mreq, 0);
    ahb(0, sbc_sup_pkg::FAIL_CTRL, 0);
    chk("sr_defaults", rd, 32'h8);
    ahb(1, sbc_sup_pkg::MODE_CTRL, 3);
    tick(3);
    chk("sr_ro_low", rst_pin, 0);
    tick(RD + 6);
    chk("sr_ro_rel", rst_pin, 1);
    @(posedge clk) begin
      nrst <= 1'b0;
      strap_low <= 1'b1;
      mode <= sbc_sup_pkg::MODE_INIT;
    end
    tick(16);
    @(posedge clk) nrst <= 1'b1;
    tick(1300);
    @(posedge clk) mode <= sbc_sup_pkg::MODE_NORMAL;
    tick(3);
    chk("dev_low_strap", dev, 1);
    @(posedge clk) begin
      strap_low <= 1'b0;
      mode <= sbc_sup_pkg::MODE_INIT;
    end
    tick(1300);
    @(posedge clk) mode <= sbc_sup_pkg::MODE_NORMAL;
    tick(3);
    chk("dev_latched", dev, 1);
    print_verdict();
  end
endmodule
